// ### text_seq_map.svh
// Offsets, sizes and timing counts of the message sequencer
`ifndef TEXT_SEQ_MAP_SVH
`define TEXT_SEQ_MAP_SVH
`define CLK_MHZ 20
`define TICK_US 1000
`define TICK_CYCLES (`TICK_US * `CLK_MHZ)
`define HOLD_MS 4000
`define HOLD_TICKS (`HOLD_MS * 1000 / `TICK_US)
`define SLOTS 16
`define ALARM_SLOT 4'h0
`define CONSTS 4
`define DIGITS 5
`define DIGIT_MAX 4'h9
`define DISP_COLS 16
`define DISP_LINES 4
`endif

// ### text_seq_pkg.sv
// Types shared by the message sequencer
`include "text_seq_map.svh"
package text_seq_pkg;
	typedef enum logic [4:0] {
		D_STATUS = 5'h01,
		D_ALARM = 5'h02,
		D_ROTATE = 5'h04,
		D_LINGER = 5'h08,
		D_MENU = 5'h10
	} disp_t;
	typedef enum logic [3:0] {
		E_IDLE = 4'h1,
		E_SELECT = 4'h2,
		E_DIGIT = 4'h4,
		E_DONE = 4'h8
	} entry_t;
	typedef struct packed {
		logic alt;
		logic ok;
		logic esc;
		logic del;
		logic up;
		logic down;
		logic left;
		logic right;
	} keys_t;
	typedef struct packed {
		logic valid;
		logic [1:0] idx;
		logic [`DIGITS*4-1:0] value;
	} commit_t;
endpackage

// ### text_seq.sv
// Message slot sequencer with keypad setpoint entry
// Operation
// - Alarm slot text stays until enable clears, stop, power off or menu.
// - Enabled rotating slots are shown in turn, advancing every 4 s.
// - Rotation stops when no other slot enabled, stop, power off or menu.
// - Alarm slot preempts and ends any rotation.
// - OK, or DEL with ALT, opens a menu and ends text display, except from status in stop mode.
// - During entry text is held static while live values keep refreshing.
// - ALT on an editable message enters entry, cursor on first value.
// - Before selection up/down move between editable constants.
// - OK on a constant starts digit edit at least significant digit.
// - In digit edit up/down change digit, left/right move place.
// - In digit edit OK commits, ESC abandons and keeps old value.
// - After commit ALT or ESC leaves entry mode.
// - After enable drops, status display returns after 4 s.
// - Each slot drives its active contact while it is shown.
// - Message area is at most 16 columns by 4 lines.
`timescale 1ns/1ps
`default_nettype none
`include "text_seq_map.svh"
module text_seq #(
	parameter int unsigned PRESCALE = `TICK_CYCLES,
	parameter int unsigned HOLD_TICKS = `HOLD_TICKS
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [`SLOTS-1:0] slotEn,
	input wire logic stopMode,
	input wire text_seq_pkg::keys_t keyPins,
	input wire logic msgEditable,
	input wire logic [2:0] constCount,
	output logic [3:0] shownSlot,
	output text_seq_pkg::disp_t dispState,
	output logic [`SLOTS-1:0] textActive,
	output logic statusShown,
	output logic menuOpen,
	output logic textFrozen,
	output logic liveRefresh,
	output logic entryMode,
	output logic digitEdit,
	output logic [1:0] cursorConst,
	output logic [2:0] cursorDigit,
	output logic [1:0] cursorLine,
	output logic [3:0] cursorCol,
	output logic [`DIGITS*4-1:0] editValue,
	output text_seq_pkg::commit_t commit
);
	localparam logic [15:0] PRESC_LAST = 16'(PRESCALE - 1);
	localparam logic [11:0] HOLD_LAST = 12'(HOLD_TICKS - 1);
	localparam logic [2:0] DIG_LAST = 3'(`DIGITS - 1);
	localparam logic [3:0] COL_LAST = 4'(`DISP_COLS - 1);

	text_seq_pkg::keys_t keyS1_ff, keyS2_ff, keyPrev_ff;
	text_seq_pkg::keys_t keyEv, keyLvl;
	text_seq_pkg::disp_t disp_ff, nxt_disp;
	text_seq_pkg::entry_t entry_ff, nxt_entry;
	text_seq_pkg::commit_t commit_ff, nxt_commit;
	logic [3:0] shown_ff, nxt_shown, nxtRot;
	logic [15:0] presc_ff;
	logic [11:0] hold_ff;
	logic [1:0] cc_ff, nxt_cc, ccMax;
	logic [2:0] cd_ff, nxt_cd;
	logic [`DIGITS*4-1:0] edit_ff, nxt_edit;
	logic [`DIGITS*4-1:0] constVal_ff [`CONSTS];
	logic [`SLOTS-1:0] active_ff;
	logic [3:0] digit;
	wire logic [`SLOTS-1:0] rotEn = slotEn & 16'hFFFE;
	wire logic alarmOn = slotEn[`ALARM_SLOT];
	wire logic anyRot = |rotEn;
	wire logic curEn = slotEn[shown_ff];
	wire logic otherEn = (nxtRot != shown_ff) && rotEn[nxtRot];
	wire logic showing = (disp_ff == text_seq_pkg::D_ALARM) ||
		(disp_ff == text_seq_pkg::D_ROTATE);
	wire logic entryIdle = entry_ff == text_seq_pkg::E_IDLE;
	wire logic delAlt = (keyEv.del && keyLvl.alt) ||
		(keyEv.alt && keyLvl.del);
	wire logic menuReq = delAlt || (keyEv.ok && entryIdle);
	wire logic tick = presc_ff == PRESC_LAST;
	wire logic timerDone = tick && (hold_ff == 12'h000);
	wire logic reload = (nxt_disp != disp_ff) ||
		(nxt_shown != shown_ff) || timerDone;
	wire logic entryKill = (nxt_disp != disp_ff) ||
		(nxt_shown != shown_ff) || !msgEditable;

	// Round robin over slots 1..15, nearest enabled after cur
	function automatic logic [3:0] nextSlot(
		input logic [15:0] en,
		input logic [3:0] cur
	);
		logic [4:0] t;
		logic [3:0] res;
		res = cur;
		for (int i = 15; i >= 1; i--) begin
			t = {1'b0, cur} + 5'(i);
			if (t > 5'h0F) begin
				t = t - 5'h0F;
			end
			if (en[t[3:0]]) begin
				res = t[3:0];
			end
		end
		return res;
	endfunction

	assign nxtRot = nextSlot(rotEn, shown_ff);
	assign keyLvl = keyS2_ff;
	assign keyEv = text_seq_pkg::keys_t'(keyS2_ff & ~keyPrev_ff);
	assign ccMax = (constCount == 3'h0) ? 2'h0 : 2'(constCount - 3'h1);
	assign digit = edit_ff[{cd_ff, 2'b00} +: 4];

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			keyS1_ff <= '0;
			keyS2_ff <= '0;
			keyPrev_ff <= '0;
		end else begin
			keyS1_ff <= keyPins;
			keyS2_ff <= keyS1_ff;
			keyPrev_ff <= keyS2_ff;
		end
	end

	always_comb begin
		nxt_disp = disp_ff;
		nxt_shown = shown_ff;
		unique case (disp_ff)
			text_seq_pkg::D_STATUS: begin
				if (stopMode) begin
					nxt_disp = text_seq_pkg::D_STATUS;
				end else if (menuReq) begin
					nxt_disp = text_seq_pkg::D_MENU;
				end else if (alarmOn) begin
					nxt_disp = text_seq_pkg::D_ALARM;
				end else if (anyRot) begin
					nxt_disp = text_seq_pkg::D_ROTATE;
					nxt_shown = nxtRot;
				end
			end
			text_seq_pkg::D_ALARM: begin
				if (menuReq) begin
					nxt_disp = text_seq_pkg::D_MENU;
				end else if (stopMode) begin
					nxt_disp = text_seq_pkg::D_STATUS;
				end else if (!alarmOn) begin
					nxt_disp = text_seq_pkg::D_LINGER;
				end
			end
			text_seq_pkg::D_ROTATE: begin
				if (menuReq) begin
					nxt_disp = text_seq_pkg::D_MENU;
					nxt_shown = `ALARM_SLOT;
				end else if (stopMode) begin
					nxt_disp = text_seq_pkg::D_STATUS;
					nxt_shown = `ALARM_SLOT;
				end else if (alarmOn) begin
					nxt_disp = text_seq_pkg::D_ALARM;
					nxt_shown = `ALARM_SLOT;
				end else if (!curEn && anyRot) begin
					nxt_shown = nxtRot;
				end else if (!curEn) begin
					nxt_disp = text_seq_pkg::D_LINGER;
				end else if (timerDone && entryIdle && otherEn) begin
					nxt_shown = nxtRot;
				end
			end
			text_seq_pkg::D_LINGER: begin
				if (menuReq) begin
					nxt_disp = text_seq_pkg::D_MENU;
					nxt_shown = `ALARM_SLOT;
				end else if (stopMode || timerDone) begin
					nxt_disp = text_seq_pkg::D_STATUS;
					nxt_shown = `ALARM_SLOT;
				end else if (alarmOn) begin
					nxt_disp = text_seq_pkg::D_ALARM;
					nxt_shown = `ALARM_SLOT;
				end else if (anyRot) begin
					nxt_disp = text_seq_pkg::D_ROTATE;
					nxt_shown = nxtRot;
				end
			end
			text_seq_pkg::D_MENU: begin
				if (keyEv.esc) begin
					nxt_disp = text_seq_pkg::D_STATUS;
				end
			end
			default: begin
				nxt_disp = text_seq_pkg::D_STATUS;
				nxt_shown = `ALARM_SLOT;
			end
		endcase
	end

	always_comb begin
		nxt_entry = entry_ff;
		nxt_cc = cc_ff;
		nxt_cd = cd_ff;
		nxt_edit = edit_ff;
		nxt_commit = '0;
		unique case (entry_ff)
			text_seq_pkg::E_IDLE: begin
				if (keyEv.alt && !delAlt && showing && msgEditable &&
						constCount != 3'h0) begin
					nxt_entry = text_seq_pkg::E_SELECT;
					nxt_cc = 2'h0;
				end
			end
			text_seq_pkg::E_SELECT, text_seq_pkg::E_DONE: begin
				if (keyEv.up) begin
					nxt_cc = (cc_ff == 2'h0) ? ccMax : cc_ff - 2'h1;
					nxt_entry = text_seq_pkg::E_SELECT;
				end else if (keyEv.down) begin
					nxt_cc = (cc_ff == ccMax) ? 2'h0 : cc_ff + 2'h1;
					nxt_entry = text_seq_pkg::E_SELECT;
				end else if (keyEv.alt || keyEv.esc) begin
					nxt_entry = text_seq_pkg::E_IDLE;
				end else if (keyEv.ok &&
						entry_ff == text_seq_pkg::E_DONE) begin
					// After a commit OK only walks to the next constant
					nxt_cc = (cc_ff == ccMax) ? 2'h0 : cc_ff + 2'h1;
					nxt_entry = text_seq_pkg::E_SELECT;
				end else if (keyEv.ok) begin
					nxt_entry = text_seq_pkg::E_DIGIT;
					nxt_cd = 3'h0;
					nxt_edit = constVal_ff[cc_ff];
				end
			end
			text_seq_pkg::E_DIGIT: begin
				if (keyEv.up) begin
					nxt_edit[{cd_ff, 2'b00} +: 4] =
						(digit >= `DIGIT_MAX) ? 4'h0 : digit + 4'h1;
				end else if (keyEv.down) begin
					nxt_edit[{cd_ff, 2'b00} +: 4] =
						(digit == 4'h0) ? `DIGIT_MAX : digit - 4'h1;
				end else if (keyEv.left) begin
					nxt_cd = (cd_ff == DIG_LAST) ? cd_ff : cd_ff + 3'h1;
				end else if (keyEv.right) begin
					nxt_cd = (cd_ff == 3'h0) ? cd_ff : cd_ff - 3'h1;
				end else if (keyEv.ok) begin
					nxt_entry = text_seq_pkg::E_DONE;
					nxt_commit.valid = 1'b1;
					nxt_commit.idx = cc_ff;
					nxt_commit.value = edit_ff;
				end else if (keyEv.esc) begin
					// Edit copy is dropped, stored constant untouched
					nxt_entry = text_seq_pkg::E_SELECT;
				end
			end
			default: begin
				nxt_entry = text_seq_pkg::E_IDLE;
			end
		endcase
		if (entryKill) begin
			nxt_entry = text_seq_pkg::E_IDLE;
			nxt_commit = '0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			disp_ff <= text_seq_pkg::D_STATUS;
			shown_ff <= `ALARM_SLOT;
			entry_ff <= text_seq_pkg::E_IDLE;
			cc_ff <= 2'h0;
			cd_ff <= 3'h0;
			edit_ff <= '0;
			commit_ff <= '0;
		end else begin
			disp_ff <= nxt_disp;
			shown_ff <= nxt_shown;
			entry_ff <= nxt_entry;
			cc_ff <= nxt_cc;
			cd_ff <= nxt_cd;
			edit_ff <= nxt_edit;
			commit_ff <= nxt_commit;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < `CONSTS; i++) begin
				constVal_ff[i] <= '0;
			end
		end else if (nxt_commit.valid) begin
			constVal_ff[nxt_commit.idx] <= nxt_commit.value;
		end
	end

	// Interval restarts whenever the shown slot or view changes
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			presc_ff <= 16'h0000;
			hold_ff <= HOLD_LAST;
		end else if (reload) begin
			presc_ff <= 16'h0000;
			hold_ff <= HOLD_LAST;
		end else if (tick) begin
			presc_ff <= 16'h0000;
			hold_ff <= hold_ff - 12'h001;
		end else begin
			presc_ff <= presc_ff + 16'h0001;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			active_ff <= '0;
		end else if (nxt_disp == text_seq_pkg::D_ALARM ||
				nxt_disp == text_seq_pkg::D_ROTATE ||
				nxt_disp == text_seq_pkg::D_LINGER) begin
			active_ff <= 16'h0001 << nxt_shown;
		end else begin
			active_ff <= '0;
		end
	end

	assign shownSlot = shown_ff;
	assign dispState = disp_ff;
	assign textActive = active_ff;
	assign statusShown = disp_ff == text_seq_pkg::D_STATUS;
	assign menuOpen = disp_ff == text_seq_pkg::D_MENU;
	assign textFrozen = !entryIdle;
	assign liveRefresh = showing || disp_ff == text_seq_pkg::D_LINGER;
	assign entryMode = !entryIdle;
	assign digitEdit = entry_ff == text_seq_pkg::E_DIGIT;
	assign cursorConst = cc_ff;
	assign cursorDigit = cd_ff;
	// One constant per line, right aligned in a 16 column line
	assign cursorLine = cc_ff;
	assign cursorCol = COL_LAST - {1'b0, cd_ff};
	assign editValue = edit_ff;
	assign commit = commit_ff;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	alarm_hold_a: assert property (disp_ff == text_seq_pkg::D_ALARM &&
		alarmOn && !menuReq && !stopMode |=> disp_ff == text_seq_pkg::D_ALARM)
		else $error("alarm text dropped early");
	alarm_prio_a: assert property (disp_ff == text_seq_pkg::D_ROTATE &&
		alarmOn && !menuReq && !stopMode |=> disp_ff == text_seq_pkg::D_ALARM
		&& textActive == 16'h0001)
		else $error("alarm did not preempt rotation");
	rot_step_a: assert property (disp_ff == text_seq_pkg::D_ROTATE &&
		curEn && timerDone && entryIdle && otherEn && !alarmOn && !menuReq
		&& !stopMode |=> shown_ff != $past(shown_ff))
		else $error("rotation did not advance");
	stop_end_a: assert property (stopMode && showing && !menuReq
		|=> disp_ff == text_seq_pkg::D_STATUS)
		else $error("stop did not end text");
	menu_open_a: assert property (showing && menuReq
		|=> menuOpen ##1 textActive == 16'h0000)
		else $error("menu did not end text");
	linger_end_a: assert property (disp_ff == text_seq_pkg::D_LINGER &&
		timerDone && !menuReq |=> statusShown)
		else $error("status not restored");
	freeze_a: assert property (!entryIdle |-> textFrozen && liveRefresh)
		else $error("entry without frozen text");
	entry_start_a: assert property (entryIdle && keyEv.alt && !delAlt &&
		showing && msgEditable && constCount != 3'h0 && !entryKill
		|=> entry_ff == text_seq_pkg::E_SELECT && cc_ff == 2'h0)
		else $error("entry did not start on first value");
	digit_start_a: assert property (entry_ff == text_seq_pkg::E_SELECT &&
		keyEv.ok && !keyEv.up && !keyEv.down && !keyEv.alt && !keyEv.esc
		&& !entryKill |=> digitEdit && cd_ff == 3'h0)
		else $error("digit edit not at lowest place");
	abort_keep_a: assert property (digitEdit && keyEv.esc && !keyEv.ok &&
		!keyEv.up && !keyEv.down && !keyEv.left && !keyEv.right
		|=> constVal_ff[cc_ff] == $past(constVal_ff[cc_ff]) && !commit.valid)
		else $error("abandoned edit changed value");
	exit_a: assert property (entry_ff == text_seq_pkg::E_DONE &&
		keyEv.esc && !keyEv.up && !keyEv.down |=> entryIdle)
		else $error("entry not left after commit");
	key_pulse_a: assert property (keyEv.ok |=> !keyEv.ok)
		else $error("key event longer than a cycle");

	rot_c: cover property (disp_ff == text_seq_pkg::D_ROTATE &&
		shown_ff != $past(shown_ff) && $past(disp_ff) == disp_ff);
	preempt_c: cover property (disp_ff == text_seq_pkg::D_ROTATE
		##1 disp_ff == text_seq_pkg::D_ALARM);
	commit_c: cover property (commit.valid);
endmodule // text_seq
`default_nettype wire

// ### keypad_model.sv
// Operator keypad model pressing and releasing keys
`timescale 1ns/1ps
`default_nettype none
module keypad_model (
	input wire logic clk,
	output var text_seq_pkg::keys_t keys
);
	initial begin
		keys = '0;
	end
	// Pre key is held first so a combination is one edge over a held key
	task automatic press(input logic [7:0] pre, input logic [7:0] k,
		input int hold);
		@(posedge clk);
		if (pre != 8'h00) begin
			keys <= pre;
			repeat (3) @(posedge clk);
		end
		keys <= pre | k;
		repeat (hold) @(posedge clk);
		keys <= '0;
		// Low long enough for the synchroniser and the step to land
		repeat (6) @(posedge clk);
	endtask
endmodule // keypad_model
`default_nettype wire

// ### testbench.sv
// Self-checking bench for the message slot sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam int PRE = 4;
	localparam int HT = 5;
	localparam int P = PRE * HT;
	localparam logic [7:0] K_ALT = 8'h80, K_OK = 8'h40, K_ESC = 8'h20;
	localparam logic [7:0] K_DEL = 8'h10, K_UP = 8'h08, K_DOWN = 8'h04;
	localparam logic [7:0] K_LEFT = 8'h02;
	logic clk, rst, stopMode, msgEditable;
	logic [15:0] slotEn, textActive, mask, seed;
	logic [2:0] constCount, cursorDigit;
	text_seq_pkg::keys_t keyPins;
	text_seq_pkg::disp_t dispState;
	text_seq_pkg::commit_t commit, lastCommit;
	logic [3:0] shownSlot, cursorCol;
	logic statusShown, menuOpen, textFrozen, liveRefresh, entryMode, digitEdit;
	logic [1:0] cursorConst, cursorLine;
	logic [19:0] editValue;
	int badCount = 0, checksDone = 0, pulses = 0, n;
	int q[$];
	int d[5] = '{0, 0, 0, 0, 0};
	// Short intervals so a 4 s view fits in a few dozen cycles
	text_seq #(.PRESCALE(PRE), .HOLD_TICKS(HT)) uut (.clk(clk), .rst(rst),
		.slotEn(slotEn), .stopMode(stopMode),
		.keyPins(keyPins), .msgEditable(msgEditable), .constCount(constCount),
		.shownSlot(shownSlot), .dispState(dispState), .textActive(textActive),
		.statusShown(statusShown), .menuOpen(menuOpen), .textFrozen(textFrozen),
		.liveRefresh(liveRefresh), .entryMode(entryMode), .digitEdit(digitEdit),
		.cursorConst(cursorConst), .cursorDigit(cursorDigit),
		.cursorLine(cursorLine), .cursorCol(cursorCol), .editValue(editValue),
		.commit(commit));
	keypad_model kp (.clk(clk), .keys(keyPins));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		if (commit.valid === 1'b1) begin
			pulses++;
			lastCommit <= commit;
		end
	end
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic [19:0] bcd();
		logic [19:0] v;
		for (int i = 0; i < 5; i++) v[i*4 +: 4] = d[i][3:0];
		return v;
	endfunction
	task automatic summarize();
		$display("checks %0d errors %0d", checksDone, badCount);
		if (badCount == 0 && checksDone > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checksDone++;
		if (got !== exp) begin
			badCount++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chkDisp(input text_seq_pkg::disp_t got,
		input text_seq_pkg::disp_t exp);
		checksDone++;
		if (got !== exp) begin
			badCount++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic setEn(input logic [15:0] m);
		@(posedge clk);
		slotEn <= m;
	endtask
	task automatic key(input logic [7:0] pre, input logic [7:0] k, input int h);
		kp.press(pre, k, h);
		#1;
	endtask
	// Counts cycles to the next change of view or shown slot
	task automatic waitChange(output int cnt);
		logic [3:0] old;
		logic [4:0] oldState;
		old = shownSlot;
		oldState = dispState;
		cnt = 0;
		while (shownSlot === old && dispState === oldState) begin
			cyc(1);
			cnt++;
			if (cnt > 3 * P) begin
				badCount++;
				summarize();
			end
		end
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		badCount++;
		summarize();
	end
	initial begin
		rst = 1'b1;
		slotEn = '0;
		stopMode = 1'b0;
		msgEditable = 1'b0;
		constCount = 3'h0;
		seed = 16'h002D;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		cyc(1);
		chkDisp(dispState, text_seq_pkg::D_STATUS);
		chk(textActive, 16'h0000);
		chk(commit, 23'h000000);
		for (int r = 0; r < 2; r++) begin
			seed = lfsr(lfsr(seed));
			mask = seed | 16'h8002;
			mask[0] = 1'b0;
			q.delete();
			for (int i = 1; i < 16; i++) if (mask[i]) q.push_back(i);
			setEn(mask);
			cyc(1);
			chkDisp(dispState, text_seq_pkg::D_ROTATE);
			for (int k = 0; k < 5; k++) begin
				if (k > 0) begin
					waitChange(n);
					chk(n >= P - 1 && n <= P + 1, 1);
				end
				chk(shownSlot, q[k % q.size()]);
				chk(textActive, 16'h0001 << q[k % q.size()]);
			end
			setEn(16'h0000);
			cyc(1);
			chkDisp(dispState, text_seq_pkg::D_LINGER);
			chk(textActive, 16'h0001 << q[4 % q.size()]);
			waitChange(n);
			chk(n >= P - 1 && n <= P + 1 && statusShown, 1);
			chk(textActive, 16'h0000);
		end
		setEn(16'h0006);
		cyc(3);
		setEn(16'h0007);
		cyc(1);
		chkDisp(dispState, text_seq_pkg::D_ALARM);
		chk({shownSlot, textActive}, 20'h00001);
		cyc(2 * P);
		chkDisp(dispState, text_seq_pkg::D_ALARM);
		@(posedge clk);
		stopMode <= 1'b1;
		cyc(3);
		chk(dispState != text_seq_pkg::D_ALARM, 1);
		chk(dispState != text_seq_pkg::D_ROTATE, 1);
		@(posedge clk);
		stopMode <= 1'b0;
		slotEn <= 16'h0000;
		cyc(2 * P + 4);
		chk(statusShown, 1);
		setEn(16'h0100);
		cyc(2 * P + 1);
		chk(shownSlot, 4'h8);
		key(K_DEL, K_ALT, 2);
		chk({menuOpen, shownSlot}, 5'h10);
		setEn(16'h0000);
		key(8'h00, K_ESC, 2);
		chk(statusShown, 1);
		key(8'h00, K_OK, 2);
		chk(menuOpen, 1);
		key(8'h00, K_ESC, 2);
		@(posedge clk);
		msgEditable <= 1'b1;
		constCount <= 3'h3;
		slotEn <= 16'h0002;
		cyc(2);
		key(8'h00, K_ALT, 2);
		chk({entryMode, textFrozen, liveRefresh}, 3'h7);
		chk(cursorConst, 2'h0);
		// Second slot enabled to show rotation is held off during entry
		setEn(16'h0006);
		key(8'h00, K_DOWN, 2);
		key(8'h00, K_DOWN, 2);
		key(8'h00, K_UP, 2);
		chk(cursorConst, 2'h1);
		key(8'h00, K_OK, 2);
		chk({digitEdit, cursorDigit, editValue}, 24'h800000);
		key(8'h00, K_UP, 6);
		key(8'h00, K_UP, 2);
		d[0] = (d[0] + 2) % 10;
		key(8'h00, K_LEFT, 2);
		chk({cursorLine, cursorCol, cursorDigit}, 9'h0F1);
		key(8'h00, K_DOWN, 2);
		d[1] = (d[1] + 9) % 10;
		chk(editValue, bcd());
		chk(shownSlot, 4'h1);
		key(8'h00, K_OK, 2);
		chk(pulses, 1);
		chk(lastCommit, {1'b1, 2'h1, bcd()});
		setEn(16'h0002);
		key(8'h00, K_ALT, 2);
		chk(entryMode, 0);
		key(8'h00, K_ALT, 2);
		key(8'h00, K_DOWN, 2);
		key(8'h00, K_OK, 2);
		chk(editValue, bcd());
		key(8'h00, K_UP, 2);
		chk(editValue[3:0], 4'h3);
		key(8'h00, K_ESC, 2);
		key(8'h00, K_OK, 2);
		chk({pulses[3:0], editValue}, {4'h1, bcd()});
		summarize();
	end
endmodule // testbench
`default_nettype wire
